/* shared/aslc_defs.vh */
`ifndef ASLC_DEFS_VH
`define ASLC_DEFS_VH

// register indices; byte address is four times the index
`define ASLC_IDX_LIM0 16'hf824
`define ASLC_IDX_LIM1 16'hf826
`define ASLC_IDX_MODE 16'hf828
`define ASLC_IDX_CTRL 16'hf82a
`define ASLC_IDX_EN0  16'hf82c
`define ASLC_IDX_EN1  16'hf82e
`define ASLC_IDX_GAP  16'hf832
`define ASLC_IDX_LMOD 16'hf834

// converter_mode fields
`define ASLC_MODE_DIS     8
`define ASLC_MODE_SHT_LSB 4
`define ASLC_MODE_CK_LSB  1
`define ASLC_MODE_REP     0
`define ASLC_CK_SLOW      3'h7

// converter_control fields
`define ASLC_CTRL_TRG 1
`define ASLC_CTRL_RUN 0

// limit mode register fields
`define ASLC_LMOD_EN      0
`define ASLC_LMOD_CND_LSB 8

// reset values
`define ASLC_RST_LIM  17'h0_0000
`define ASLC_RST_MODE 16'h0000
`define ASLC_RST_CTRL 2'h0
`define ASLC_RST_EN0  16'h0000
`define ASLC_RST_EN1  2'h0
`define ASLC_RST_GAP  16'h0000
`define ASLC_RST_LMOD 3'h0

// timing
`define ASLC_CLK_HZ    200000000
`define ASLC_LS_HZ     32000
`define ASLC_LS_DIV    (`ASLC_CLK_HZ / `ASLC_LS_HZ)
`define ASLC_LS_STALL  3

`endif

/* hw/aslc_top.v */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "aslc_defs.vh"

// Overview of operation
// - channel 0-15 flag sets on limit match, holds until cleared or reset.
// - no flag sets while limit detection is disabled; write-1 clears still work.
// - with detection on, interrupt at scan end if any flag is set.
// - writing 1 clears a flag bit, writing 0 leaves it.
// - limit interrupt drops when set flags are cleared or on reset.
// - second status register bit 0 flags channel 16, same behaviour.
// - mode bit 8 set discharges sample capacitor before each conversion.
// - mode bits 7-4 give the sampling time code.
// - mode bits 3-1 select conversion clock rate, 111 is 32 kHz.
// - mode bit 0 selects single scan or repeating scan.
// - control bit 1 enables hardware trigger starts.
// - control bit 0 is run: write 1 starts, 0 stops.
// - single mode clears run after the highest enabled channel finishes.
// - repeat mode scans until software writes run to 0.
// - no enabled channel means a start does nothing.
// - run set blocks stop mode entry.
// - at 32 kHz, start and stop may lag up to one slow cycle.
// - limit condition codes: inside, above upper, above lower, outside.
// - enabled channels convert in ascending order.
// - repeat gap equals interval value times system clock period; 32 kHz mode ignores the interval.
module aslc_top #(
  parameter RES_W  = 10,
  parameter LS_DIV = `ASLC_LS_DIV
) (
  input  wire             CLK,
  input  wire             RST_N,
  input  wire             CE,
  input  wire             WB_CYC_I,
  input  wire             WB_STB_I,
  input  wire             WB_WE_I,
  input  wire [17:0]      WB_ADR_I,
  input  wire [3:0]       WB_SEL_I,
  input  wire [31:0]      WB_DAT_I,
  output reg  [31:0]      WB_DAT_O,
  output reg              WB_ACK_O,
  input  wire             TRIGGER_EVENT,
  input  wire             CONV_DONE,
  input  wire [RES_W-1:0] CONV_RESULT,
  input  wire [RES_W-1:0] UPPER_THRESHOLD,
  input  wire [RES_W-1:0] LOWER_THRESHOLD,
  input  wire             STOP_REQ,
  output reg              STOP_GRANT,
  output reg              CONV_START,
  output reg  [4:0]       CONV_CHANNEL,
  output wire             CONV_DISCHARGE,
  output wire [3:0]       SAMPLE_TIME_CODE,
  output wire [2:0]       CONV_CLOCK_SELECT,
  output reg              IRQ
);

  localparam S_IDLE = 2'h0;
  localparam S_SYNC = 2'h1;
  localparam S_CONV = 2'h2;
  localparam S_GAP  = 2'h3;
  localparam LS_W   = 16;

  // software-visible state; flag bit 16 is the temperature channel
  reg  [16:0]     flags_r;
  reg  [15:0]     mode_r;
  reg             run_r;
  reg             trg_en_r;
  reg  [15:0]     en0_r;
  reg  [1:0]      en1_r;
  reg  [15:0]     gap_int_r;
  reg             lim_en_r;
  reg  [1:0]      cond_r;

  // sequencer state; the gap counter only runs between repeated scans
  reg  [1:0]      st_r;
  reg  [15:0]     gap_cnt_r;

  // interrupt memory, kept apart so a plain scan-end pulse can coexist
  reg             lim_pend_r;

  // low-speed divider: a count on the system clock, not a second domain,
  // so the slow mode needs no synchroniser on its tick
  reg  [LS_W-1:0] ls_cnt_r;
  reg             ls_tick_r;

  // read word, combinational ahead of the data register
  reg  [31:0]     rd_nxt;

  // keep lanes whose select is low
  function [15:0] aslc_merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    begin
      aslc_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                    sel[0] ? new_v[7:0]  : old_v[7:0]};
    end
  endfunction

  // lowest enabled channel at or above from; top bit says found
  // scans from the top so the lowest hit is the last one written
  function [5:0] aslc_find;
    input [17:0] en;
    input [4:0]  from;
    integer i;
    begin
      aslc_find = 6'h00;
      for (i = 17; i >= 0; i = i - 1) begin
        if (en[i] && (i >= from)) begin
          aslc_find = {1'h1, i[4:0]};
        end
      end
    end
  endfunction

  // limit test on one result
  // code 0 counts a result equal to a threshold as inside; the other codes compare strictly
  function aslc_hit;
    input [1:0]       cnd;
    input [RES_W-1:0] r;
    input [RES_W-1:0] up;
    input [RES_W-1:0] lo;
    begin
      case (cnd)
        2'h0:    aslc_hit = (r >= lo) && (r <= up);
        2'h1:    aslc_hit = r > up;
        2'h2:    aslc_hit = r > lo;
        default: aslc_hit = (r > up) || (r < lo);
      endcase
    end
  endfunction

  // bus decode; writes land on the edge that raises ack
  // ctrl and the upper enable word live in lane 0 only
  wire        wb_take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        wb_wr   = wb_take & WB_WE_I;
  wire [15:0] wb_idx  = WB_ADR_I[17:2];
  wire [15:0] wdat    = WB_DAT_I[15:0];
  wire [1:0]  wsel    = WB_SEL_I[1:0];
  wire        wr_lim0 = wb_wr & (wb_idx == `ASLC_IDX_LIM0);
  wire        wr_lim1 = wb_wr & (wb_idx == `ASLC_IDX_LIM1);
  wire        wr_mode = wb_wr & (wb_idx == `ASLC_IDX_MODE);
  wire        wr_ctrl = wb_wr & (wb_idx == `ASLC_IDX_CTRL) & wsel[0];
  wire        wr_en0  = wb_wr & (wb_idx == `ASLC_IDX_EN0);
  wire        wr_en1  = wb_wr & (wb_idx == `ASLC_IDX_EN1) & wsel[0];
  wire        wr_gap  = wb_wr & (wb_idx == `ASLC_IDX_GAP);
  wire        wr_lmod = wb_wr & (wb_idx == `ASLC_IDX_LMOD);

  // scan bookkeeping
  // done pulses after a stop are ignored, the core may still be busy
  wire [17:0] en_all  = {en1_r, en0_r};
  wire        any_en  = |en_all;
  wire        slow    = mode_r[`ASLC_MODE_CK_LSB +: 3] == `ASLC_CK_SLOW;
  wire        go_ok   = ~slow | ls_tick_r;
  wire [5:0]  first   = aslc_find(en_all, 5'h00);
  wire [5:0]  nxt_ch  = aslc_find(en_all, CONV_CHANNEL + 5'h01);
  wire        cnv_dn  = (st_r == S_CONV) & CONV_DONE & run_r;
  wire        scan_end = cnv_dn & ~nxt_ch[5];
  wire        hit = aslc_hit(cond_r, CONV_RESULT, UPPER_THRESHOLD,
                             LOWER_THRESHOLD);

  // only the finished channel may set, only with detection on
  wire [16:0] set_vec = (cnv_dn & lim_en_r & hit & (CONV_CHANNEL < 5'h11))
                        ? (17'h0_0001 << CONV_CHANNEL)
                        : 17'h0_0000;
  wire [16:0] clr_vec = {wr_lim1 & wsel[0] & wdat[0],
                         wr_lim0 ? (wdat & {{8{wsel[1]}}, {8{wsel[0]}}})
                                 : 16'h0000};
  // a set in the clearing cycle survives
  // so a result is never lost to a clear that races it
  wire [16:0] flags_nxt = (flags_r & ~clr_vec) | set_vec;

  // limit interrupt stays while any flag remains set
  // it arms only at a scan end, not on each new flag
  wire        pend_nxt = lim_en_r & |flags_nxt &
                         (lim_pend_r | scan_end);

  // low-speed tick; start and stop wait for it in 32 kHz mode
  // free-running, so start latency there is up to one tick period
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ls_cnt_r  <= {LS_W{1'h0}};
      ls_tick_r <= 1'h0;
    end else if (CE) begin
      ls_tick_r <= ls_cnt_r == LS_DIV[LS_W-1:0] - 1'h1;
      if (ls_cnt_r == LS_DIV[LS_W-1:0] - 1'h1) begin
        ls_cnt_r <= {LS_W{1'h0}};
      end else begin
        ls_cnt_r <= ls_cnt_r + 1'h1;
      end
    end
  end

  // configuration registers and flags
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_r   <= `ASLC_RST_LIM;
      mode_r    <= `ASLC_RST_MODE;
      en0_r     <= `ASLC_RST_EN0;
      en1_r     <= `ASLC_RST_EN1;
      gap_int_r <= `ASLC_RST_GAP;
      {cond_r, lim_en_r} <= `ASLC_RST_LMOD;
      trg_en_r  <= 1'h0;
    end else if (CE) begin
      // clears work per byte lane, so a byte write touches only its half
      flags_r <= flags_nxt;
      // upper bits stored as written; software keeps them zero
      if (wr_mode) begin
        mode_r <= aslc_merge(mode_r, wdat, wsel);
      end
      // trigger enable only; the run bit lives with the sequencer
      if (wr_ctrl) begin
        trg_en_r <= wdat[`ASLC_CTRL_TRG];
      end
      // channel enables; nothing exists above channel 17
      if (wr_en0) begin
        en0_r <= aslc_merge(en0_r, wdat, wsel);
      end
      if (wr_en1) begin
        en1_r <= wdat[1:0];
      end
      if (wr_gap) begin
        gap_int_r <= aslc_merge(gap_int_r, wdat, wsel);
      end
      // detection enable and condition sit in separate lanes
      if (wr_lmod && wsel[0]) begin
        lim_en_r <= wdat[`ASLC_LMOD_EN];
      end
      if (wr_lmod && wsel[1]) begin
        cond_r <= wdat[`ASLC_LMOD_CND_LSB +: 2];
      end
    end
  end

  // run bit and scan sequencer
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_r        <= 1'h0;
      st_r         <= S_IDLE;
      gap_cnt_r    <= 16'h0000;
      CONV_START   <= 1'h0;
      CONV_CHANNEL <= 5'h00;
    end else if (CE) begin
      CONV_START <= 1'h0;
      case (st_r)
        // a run request waits in sync one cycle, or until the slow tick in 32 kHz mode, before any start
        S_IDLE: begin
          if (run_r) begin
            st_r <= S_SYNC;
          end
        end
        // a stop seen before the first start ends the scan quietly
        S_SYNC: begin
          if (go_ok) begin
            if (!run_r || !first[5]) begin
              run_r <= 1'h0;
              st_r  <= S_IDLE;
            end else begin
              CONV_START   <= 1'h1;
              CONV_CHANNEL <= first[4:0];
              st_r         <= S_CONV;
            end
          end
        end
        // one channel in flight; the core answers with a done pulse
        S_CONV: begin
          if (!run_r) begin
            if (go_ok) begin
              st_r <= S_IDLE;
            end
          end else if (CONV_DONE) begin
            // next channel back to back, no idle cycle between them
            if (nxt_ch[5]) begin
              CONV_START   <= 1'h1;
              CONV_CHANNEL <= nxt_ch[4:0];
            end else if (mode_r[`ASLC_MODE_REP]) begin
              // 32 kHz mode ignores the interval; the gap state lasts one cycle
              gap_cnt_r <= slow ? 16'h0000 : gap_int_r;
              st_r      <= S_GAP;
            end else begin
              run_r <= 1'h0;
              st_r  <= S_IDLE;
            end
          end
        end
        // interval between repeated scans, at least one cycle
        S_GAP: begin
          if (!run_r) begin
            if (go_ok) begin
              st_r <= S_IDLE;
            end
          end else if (gap_cnt_r <= 16'h0001) begin
            st_r <= S_SYNC;
          end else begin
            gap_cnt_r <= gap_cnt_r - 16'h0001;
          end
        end
        // unreachable codes fall back to idle
        default: begin
          st_r <= S_IDLE;
        end
      endcase
      // software and trigger starts; refused with no channel enabled
      // a write wins over a trigger landing on the same edge
      if (wr_ctrl) begin
        run_r <= wdat[`ASLC_CTRL_RUN] & any_en;
      end else if (TRIGGER_EVENT && trg_en_r && !run_r && any_en &&
                   st_r == S_IDLE) begin
        run_r <= 1'h1;
      end
    end
  end

  // interrupt and stop-mode handshake
  // grant waits for the sequencer too, not only for the run bit
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lim_pend_r <= 1'h0;
      IRQ        <= 1'h0;
      STOP_GRANT <= 1'h0;
    end else if (CE) begin
      lim_pend_r <= pend_nxt;
      // plain scan-end pulse unless limit detection owns the line
      IRQ <= lim_en_r ? pend_nxt : scan_end;
      STOP_GRANT <= STOP_REQ & ~run_r & (st_r == S_IDLE);
    end
  end

  // read mux; unmapped words read zero
  // decoded from the live bus so the data is ready with ack
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_idx)
      `ASLC_IDX_LIM0: rd_nxt[15:0] = flags_r[15:0];
      `ASLC_IDX_LIM1: rd_nxt[0]    = flags_r[16];
      `ASLC_IDX_MODE: rd_nxt[15:0] = mode_r;
      `ASLC_IDX_CTRL: rd_nxt[1:0]  = {trg_en_r, run_r};
      `ASLC_IDX_EN0:  rd_nxt[15:0] = en0_r;
      `ASLC_IDX_EN1:  rd_nxt[1:0]  = en1_r;
      `ASLC_IDX_GAP:  rd_nxt[15:0] = gap_int_r;
      `ASLC_IDX_LMOD: rd_nxt[15:0] = {6'h00, cond_r, 7'h00, lim_en_r};
      default:        rd_nxt       = 32'h0000_0000;
    endcase
  end

  // one wait state, ack for one cycle, every address answered
  // ack low in the take term keeps a held request from retriggering
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'h0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE) begin
      WB_ACK_O <= wb_take;
      if (wb_take && !WB_WE_I) begin
        WB_DAT_O <= rd_nxt;
      end
    end
  end

  // analog-side settings come straight from the mode register flops
  assign CONV_DISCHARGE    = mode_r[`ASLC_MODE_DIS];
  assign SAMPLE_TIME_CODE  = mode_r[`ASLC_MODE_SHT_LSB +: 4];
  assign CONV_CLOCK_SELECT = mode_r[`ASLC_MODE_CK_LSB +: 3];

endmodule
`default_nettype wire

/* tb/aslc_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module aslc_assertions (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [17:0] WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CONV_DONE,
  input wire logic        STOP_REQ,
  input wire logic        STOP_GRANT,
  input wire logic        CONV_START,
  input wire logic [4:0]  CONV_CHANNEL,
  input wire logic        CONV_DISCHARGE,
  input wire logic [3:0]  SAMPLE_TIME_CODE,
  input wire logic [2:0]  CONV_CLOCK_SELECT,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // request not yet answered, and a write of the mode register
  wire req = CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire mw  = req && WB_WE_I && WB_ADR_I[17:2] == 16'hf828;
  chk_ack_after_req: assert property (req |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req))
    else $error("ack without request");
  chk_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_disch_map: assert property (mw && WB_SEL_I[1] |=> CONV_DISCHARGE == $past(WB_DAT_I[8]))
    else $error("discharge output not mode bit 8");
  chk_mode_low: assert property (mw && WB_SEL_I[0] |=>
    {SAMPLE_TIME_CODE, CONV_CLOCK_SELECT} == $past(WB_DAT_I[7:1]))
    else $error("sample time or clock select not mode bits 7 to 1");
  chk_start_pulse: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse longer than one cycle");
  chk_stop_run: assert property (CONV_START |-> !STOP_GRANT)
    else $error("stop granted while converting");
  chk_grant_cause: assert property (STOP_GRANT |-> $past(STOP_REQ))
    else $error("stop granted without request");
  chk_irq_scan_end: assert property ($rose(IRQ) |-> $past(CONV_DONE))
    else $error("interrupt not at scan end");
  // main scenarios reached
  cover property ($rose(IRQ));
  cover property (CONV_START && CONV_CHANNEL == 5'h10);
  cover property (STOP_GRANT);
endmodule
bind aslc_top aslc_assertions aslc_assertions_i (.*);
`default_nettype wire

/* tb/aslc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aslc_core_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       start,
  input wire logic [4:0] chan,
  input wire logic [3:0] lag,
  output logic           done,
  output logic [9:0]     result
);
  logic [3:0] cnt_r;
  logic       busy_r;
  // result is channel times 32; toggles outside done so stale data never matches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'h0;
      cnt_r <= 4'h0;
      done <= 1'h0;
      result <= 10'h3ff;
    end else begin
      done <= 1'h0;
      result <= ~result;
      if (start) begin
        busy_r <= 1'h1;
        cnt_r <= lag;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'h0;
        done <= 1'h1;
        result <= {chan, 5'h00};
      end
    end
  end
endmodule
`default_nettype wire

/* tb/aslc_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "aslc_defs.vh"
module aslc_top_bench;
  logic        clk, rst_n, cyc, stb, we, trg, stop_req, ack, done, start, irq, grant;
  logic [17:0] adr;
  logic [3:0]  sel, lag;
  logic [31:0] wdat, rdat;
  logic [15:0] q;
  logic [9:0]  res;
  logic [4:0]  chan;
  logic [7:0]  mo;
  logic [4:0]  order [$];
  int          fails, checks, ticks, starts, n;
  // index, value written, value read back
  logic [47:0] rows [8] = '{
    {`ASLC_IDX_MODE, 16'h01f6, 16'h01f6}, {`ASLC_IDX_GAP, 16'h0003, 16'h0003},
    {`ASLC_IDX_EN0, 16'h0005, 16'h0005}, {`ASLC_IDX_EN1, 16'h0001, 16'h0001},
    {`ASLC_IDX_LMOD, 16'h0301, 16'h0301}, {16'hf830, 16'hffff, 16'h0000},
    {`ASLC_IDX_LIM0, 16'hffff, 16'h0000}, {`ASLC_IDX_CTRL, 16'h0002, 16'h0002}};
  aslc_top #(.LS_DIV(8)) aslc_top_i (.CLK(clk), .RST_N(rst_n), .CE(1'h1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .TRIGGER_EVENT(trg),
    .CONV_DONE(done), .CONV_RESULT(res), .UPPER_THRESHOLD(10'h064),
    .LOWER_THRESHOLD(10'h00a), .STOP_REQ(stop_req), .STOP_GRANT(grant),
    .CONV_START(start), .CONV_CHANNEL(chan), .CONV_DISCHARGE(mo[7]),
    .SAMPLE_TIME_CODE(mo[6:3]), .CONV_CLOCK_SELECT(mo[2:0]), .IRQ(irq));
  aslc_core_model aslc_core_model_i (.clk(clk), .rst_n(rst_n), .start(start),
    .chan(chan), .lag(lag), .done(done), .result(res));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // cycle budget, and a log of conversion starts
  always @(posedge clk) begin
    ticks++;
    if (start === 1'h1) begin
      starts++;
      order.push_back(chan);
    end
    if (ticks == 30000) begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string w, input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  // one classic cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [15:0] i, d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'h1);
    q = rdat[15:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] i, d);
    wb(1'h1, i, d);
  endtask
  task automatic rd(input logic [15:0] i, e);
    wb(1'h0, i, 16'h0000);
    cmp($sformatf("reg %h", i), q, e);
  endtask
  task automatic idle;
    do wb(1'h0, `ASLC_IDX_CTRL, 16'h0000); while (q[0] !== 1'h0);
  endtask
  function automatic logic hit(int c, int r);
    case (c)
      0: return r >= 10 && r <= 100;
      1: return r > 100;
      2: return r > 10;
      default: return r > 100 || r < 10;
    endcase
  endfunction
  initial begin
    {cyc, stb, we, trg, stop_req, rst_n} = 6'h00;
    {adr, sel, wdat, lag} = 58'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    stop_req <= 1'h1;
    @(posedge clk);
    foreach (rows[i]) rd(rows[i][47:32], 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i][47:32], rows[i][31:16]);
      rd(rows[i][47:32], rows[i][15:0]);
    end
    cmp("mode pins", 16'(mo), 16'h00fb);
    // trigger start, then trigger with starts disabled
    trg <= 1'h1;
    @(posedge clk);
    trg <= 1'h0;
    while (irq !== 1'h1) @(posedge clk);
    cmp("trigger starts", 16'(starts), 16'h0003);
    wr(`ASLC_IDX_CTRL, 16'h0000);
    trg <= 1'h1;
    @(posedge clk);
    trg <= 1'h0;
    rd(`ASLC_IDX_CTRL, 16'h0000);
    cmp("trigger off starts", 16'(starts), 16'h0003);
    // every limit condition, core prompt then slow
    for (int c = 0; c < 4; c++) begin
      wr(`ASLC_IDX_LIM0, 16'hffff);
      wr(`ASLC_IDX_LIM1, 16'h0001);
      wr(`ASLC_IDX_LMOD, {6'h00, c[1:0], 8'h01});
      lag <= c[3:0] * 4'h5;
      order.delete();
      rd(`ASLC_IDX_LIM1, 16'h0000);
      wr(`ASLC_IDX_CTRL, 16'h0001);
      while (irq !== 1'h1) @(posedge clk);
      rd(`ASLC_IDX_CTRL, 16'h0000);
      cmp("channels", 16'(order.size()), 16'h0003);
      foreach (order[i]) cmp("channel", order[i], (i == 2) ? 16'h0010 : 16'(2 * i));
      rd(`ASLC_IDX_LIM0, {13'h0000, hit(c, 64), 1'h0, hit(c, 0)});
      wr(`ASLC_IDX_LIM1, 16'h0000);
      rd(`ASLC_IDX_LIM1, {15'h0000, hit(c, 512)});
      wr(`ASLC_IDX_LIM0, 16'hffff);
      cmp("irq", irq, hit(c, 512));
      wr(`ASLC_IDX_LIM1, 16'h0001);
      cmp("irq", irq, 16'h0000);
      rd(`ASLC_IDX_LIM0, 16'h0000);
    end
    // detection off leaves flags alone
    wr(`ASLC_IDX_LMOD, 16'h0300);
    wr(`ASLC_IDX_CTRL, 16'h0001);
    idle;
    rd(`ASLC_IDX_LIM0, 16'h0000);
    rd(`ASLC_IDX_LIM1, 16'h0000);
    // no channel enabled: run refused
    wr(`ASLC_IDX_EN0, 16'h0000);
    wr(`ASLC_IDX_EN1, 16'h0000);
    n = starts;
    wr(`ASLC_IDX_CTRL, 16'h0001);
    rd(`ASLC_IDX_CTRL, 16'h0000);
    cmp("starts idle", 16'(starts), 16'(n));
    wr(`ASLC_IDX_EN0, 16'h0005);
    wr(`ASLC_IDX_EN1, 16'h0001);
    // repeating scan runs until run is written 0
    wr(`ASLC_IDX_MODE, 16'h01f7);
    wr(`ASLC_IDX_CTRL, 16'h0001);
    while (starts < n + 7) @(posedge clk);
    rd(`ASLC_IDX_CTRL, 16'h0001);
    wr(`ASLC_IDX_CTRL, 16'h0000);
    rd(`ASLC_IDX_CTRL, 16'h0000);
    n = starts;
    rd(`ASLC_IDX_CTRL, 16'h0000);
    cmp("starts after stop", 16'(starts), 16'(n));
    // slow conversion clock still completes a single scan
    wr(`ASLC_IDX_MODE, 16'h000e);
    wr(`ASLC_IDX_CTRL, 16'h0001);
    idle;
    cmp("stop grant", grant, 16'h0001);
    // reset in mid-scan returns ctrl, mode and the low enable word to their reset values
    wr(`ASLC_IDX_MODE, 16'h0001);
    wr(`ASLC_IDX_CTRL, 16'h0001);
    n = starts;
    while (starts < n + 2) @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`ASLC_IDX_CTRL, 16'h0000);
    rd(`ASLC_IDX_MODE, 16'h0000);
    rd(`ASLC_IDX_EN0, 16'h0000);
    cmp("irq after reset", irq, 16'h0000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
